// [rtl/rtcm_top.sv]
// register map, time counters, read snapshot and alarm match of the serial clock device
`timescale 1ns/1ns
`default_nettype none
`include "rtcm_consts.svh"

module rtcm_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hundTick,
  input wire logic powerFail,
  input wire logic oscStopped,
  input wire logic linkClk,
  input wire logic linkSel_n,
  input wire logic linkDin,
  output logic linkDout,
  output logic linkDoutEn_n,
  output logic oscStopOnBattery,
  output logic batteryOutputEnable,
  output logic waveRateHigh,
  output logic waveRateLow,
  output logic interruptPinSelect,
  output logic alarmIrqEnable,
  output logic alarmMatchFlag,
  output logic oscillatorStopFlag,
  output logic [7:0] chargePathSetup
);
  rtcm_pkg::rtcm_byte_t hund_r;
  rtcm_pkg::rtcm_byte_t sec_r;
  rtcm_pkg::rtcm_byte_t min_r;
  rtcm_pkg::rtcm_byte_t hrs_r;
  rtcm_pkg::rtcm_byte_t wday_r;
  rtcm_pkg::rtcm_byte_t date_r;
  rtcm_pkg::rtcm_byte_t mon_r;
  rtcm_pkg::rtcm_byte_t year_r;
  rtcm_pkg::rtcm_byte_t almHund_r;
  rtcm_pkg::rtcm_byte_t almSec_r;
  rtcm_pkg::rtcm_byte_t almMin_r;
  rtcm_pkg::rtcm_byte_t almHrs_r;
  rtcm_pkg::rtcm_byte_t almDdt_r;
  rtcm_pkg::rtcm_byte_t ctrl_r;
  rtcm_pkg::rtcm_byte_t flags_r;
  rtcm_pkg::rtcm_byte_t charge_r;
  rtcm_pkg::rtcm_byte_t rdData_r;
  rtcm_pkg::rtcm_byte_t snap_r [0:7];
  rtcm_pkg::rtcm_byte_t hundNxt;
  rtcm_pkg::rtcm_byte_t secNxt;
  rtcm_pkg::rtcm_byte_t minNxt;
  rtcm_pkg::rtcm_byte_t hrsNxt;
  rtcm_pkg::rtcm_byte_t wdayNxt;
  rtcm_pkg::rtcm_byte_t dateNxt;
  rtcm_pkg::rtcm_byte_t monNxt;
  rtcm_pkg::rtcm_byte_t yearNxt;
  rtcm_pkg::rtcm_byte_t rdVal;
  rtcm_pkg::rtcm_byte_t wrVal;
  logic cHund;
  logic cSec;
  logic cMin;
  logic cHrs;
  logic cDate;
  logic cMon;
  logic cYear;
  logic [8:0] step;
  logic evtTog;
  logic evtWr;
  logic [3:0] evtWrAddr;
  logic [7:0] evtData;
  logic [3:0] evtPtr;
  logic [3:0] syncOut;
  logic evtSync;
  logic selSync_n;
  logic pfSync;
  logic oscStopSync;
  logic evtSeen_r;
  logic selPrev_n_r;
  logic tickDly_r;
  logic evtNew;
  logic wrEn;
  logic snapTake;
  logic alarmHit;

  // packed BCD increment: returns {wrap, next}, wrapping from last to first
  function automatic logic [8:0] bcdStep(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    logic [8:0] r;
    if (v == last) begin
      r = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v + 8'h01};
    end
    return r;
  endfunction

  // leap years from the BCD year: low two bits of the units digit plus twice the tens lsb; good up to 2099
  function automatic logic [7:0] lastDay(input logic [7:0] mon, input logic [7:0] yr);
    logic [1:0] rem4;
    logic [7:0] r;
    rem4 = yr[1:0] + {yr[4], 1'b0};
    case ({3'h0, mon[4:0]})
      `RTCM_BCD_02: r = (rem4 == 2'h0) ? `RTCM_BCD_29 : `RTCM_BCD_28;
      `RTCM_BCD_04, `RTCM_BCD_06, `RTCM_BCD_09, `RTCM_BCD_11: r = `RTCM_BCD_30;
      default: r = `RTCM_BCD_31;
    endcase
    return r;
  endfunction

  // implemented bits of each register; all others are held at zero
  function automatic logic [7:0] regMask(input logic [3:0] a);
    logic [7:0] m;
    case (a)
      `RTCM_A_SEC, `RTCM_A_MIN, `RTCM_A_HRS: m = `RTCM_M_SEVEN;
      `RTCM_A_WDAY: m = `RTCM_M_WDAY;
      `RTCM_A_DATE: m = `RTCM_M_DATE;
      `RTCM_A_MON: m = `RTCM_M_MON;
      `RTCM_A_CTRL: m = `RTCM_M_CTRL;
      `RTCM_A_FLAGS: m = `RTCM_M_FLAGS;
      default: m = `RTCM_M_FULL;
    endcase
    return m;
  endfunction

  rtcm_link uLink (
    .linkClk(linkClk),
    .linkSel_n(linkSel_n),
    .rst_n(rst_n),
    .linkDin(linkDin),
    .rdByte(rdData_r),
    .linkDout(linkDout),
    .linkDoutEn_n(linkDoutEn_n),
    .evtTog(evtTog),
    .evtWr(evtWr),
    .evtWrAddr(evtWrAddr),
    .evtData(evtData),
    .evtPtr(evtPtr)
  );

  rtcm_sync #(
    .WIDTH(4)
  ) uSync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .asyncIn({evtTog, linkSel_n, powerFail, oscStopped}),
    .syncOut(syncOut)
  );

  assign {evtSync, selSync_n, pfSync, oscStopSync} = syncOut;
  assign evtNew = evtSync != evtSeen_r;
  assign snapTake = selPrev_n_r && !selSync_n;
  // power fail blocks every access; writes in that state are dropped
  assign wrEn = evtNew && evtWr && !pfSync;
  assign wrVal = evtData & regMask(evtWrAddr);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      evtSeen_r <= 1'b0;
      selPrev_n_r <= 1'b0;
      tickDly_r <= 1'b0;
    end else if (ce) begin
      evtSeen_r <= evtSync;
      selPrev_n_r <= selSync_n;
      tickDly_r <= hundTick;
    end
  end

  // next values of the calendar chain and the carry out of each stage but the weekday
  always_comb begin
    {cHund, hundNxt} = bcdStep(hund_r, `RTCM_BCD_99, `RTCM_BCD_00);
    {cSec, secNxt} = bcdStep({1'b0, sec_r[6:0]}, `RTCM_BCD_59, `RTCM_BCD_00);
    {cMin, minNxt} = bcdStep({1'b0, min_r[6:0]}, `RTCM_BCD_59, `RTCM_BCD_00);
    if (hrs_r[`RTCM_HRS_12H]) begin
      step = bcdStep({3'h0, hrs_r[4:0]}, `RTCM_BCD_12, `RTCM_BCD_01);
      cHrs = hrs_r[`RTCM_HRS_PM] && hrs_r[4:0] == 5'(`RTCM_BCD_11);
      hrsNxt = {hrs_r[7:6], hrs_r[`RTCM_HRS_PM] ^ (hrs_r[4:0] == 5'(`RTCM_BCD_11)), step[4:0]};
    end else begin
      step = bcdStep({2'h0, hrs_r[5:0]}, `RTCM_BCD_23, `RTCM_BCD_00);
      cHrs = step[8];
      hrsNxt = {hrs_r[7:6], step[5:0]};
    end
    wdayNxt = 8'(bcdStep({5'h0, wday_r[2:0]}, `RTCM_BCD_07, `RTCM_BCD_01));
    {cDate, dateNxt} = bcdStep({2'h0, date_r[5:0]}, lastDay(mon_r, year_r), `RTCM_BCD_01);
    {cYear, yearNxt} = bcdStep(year_r, `RTCM_BCD_99, `RTCM_BCD_00);
    {cMon, monNxt} = bcdStep({3'h0, mon_r[4:0]}, `RTCM_BCD_12, `RTCM_BCD_01);
    monNxt[`RTCM_MON_CENT] = mon_r[`RTCM_MON_CENT] ^ (cMon && cYear);
  end

  // running counters have no reset; a write in the tick cycle wins for its byte
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (hundTick) begin
        hund_r <= hundNxt;
        if (cHund) begin
          sec_r <= secNxt;
          if (cSec) begin
            min_r <= minNxt;
            if (cMin) begin
              hrs_r <= hrsNxt;
              if (cHrs) begin
                wday_r <= wdayNxt;
                date_r <= dateNxt;
                if (cDate) begin
                  mon_r <= monNxt;
                  if (cMon) begin
                    year_r <= yearNxt;
                  end
                end
              end
            end
          end
        end
      end
      if (wrEn) begin
        case (evtWrAddr)
          `RTCM_A_HUND: hund_r <= wrVal;
          `RTCM_A_SEC: sec_r <= wrVal;
          `RTCM_A_MIN: min_r <= wrVal;
          `RTCM_A_HRS: hrs_r <= wrVal;
          `RTCM_A_WDAY: wday_r <= wrVal;
          `RTCM_A_DATE: date_r <= wrVal;
          `RTCM_A_MON: mon_r <= wrVal;
          `RTCM_A_YEAR: year_r <= wrVal;
          default: ;
        endcase
      end
    end
  end

  // snapshot keeps reads coherent across a rollover during the frame
  always_ff @(posedge sys_clk) begin
    if (ce && snapTake) begin
      snap_r[0] <= hund_r;
      snap_r[1] <= sec_r;
      snap_r[2] <= min_r;
      snap_r[3] <= hrs_r;
      snap_r[4] <= wday_r;
      snap_r[5] <= date_r;
      snap_r[6] <= mon_r;
      snap_r[7] <= year_r;
    end
  end

  // alarm match registers are left without reset on purpose
  always_ff @(posedge sys_clk) begin
    if (ce && wrEn) begin
      case (evtWrAddr)
        `RTCM_A_ALM_HUND: almHund_r <= wrVal;
        `RTCM_A_ALM_SEC: almSec_r <= wrVal;
        `RTCM_A_ALM_MIN: almMin_r <= wrVal;
        `RTCM_A_ALM_HRS: almHrs_r <= wrVal;
        `RTCM_A_ALM_DDT: almDdt_r <= wrVal;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= `RTCM_CTRL_RST;
      charge_r <= `RTCM_CHARGE_RST;
    end else if (ce && wrEn) begin
      if (evtWrAddr == `RTCM_A_CTRL) begin
        ctrl_r <= wrVal;
      end
      if (evtWrAddr == `RTCM_A_CHARGE) begin
        charge_r <= wrVal;
      end
    end
  end

  // F in a hundredths nibble masks that digit; bit 7 masks the other fields
  always_comb begin
    alarmHit = (almHund_r[7:4] == `RTCM_NIB_MASKED || almHund_r[7:4] == hund_r[7:4]) &&
               (almHund_r[3:0] == `RTCM_NIB_MASKED || almHund_r[3:0] == hund_r[3:0]);
    alarmHit = alarmHit && (almSec_r[`RTCM_ALM_MASK] || almSec_r[6:0] == sec_r[6:0]);
    alarmHit = alarmHit && (almMin_r[`RTCM_ALM_MASK] || almMin_r[6:0] == min_r[6:0]);
    alarmHit = alarmHit && (almHrs_r[`RTCM_ALM_MASK] || almHrs_r[6:0] == hrs_r[6:0]);
    if (!almDdt_r[`RTCM_ALM_MASK]) begin
      if (almDdt_r[`RTCM_ALM_DAY]) begin
        alarmHit = alarmHit && almDdt_r[3:0] == wday_r[3:0];
      end else begin
        alarmHit = alarmHit && almDdt_r[5:0] == date_r[5:0];
      end
    end
  end

  // flags clear where software writes zero; a same-cycle event still sets
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags_r <= `RTCM_FLAGS_RST;
    end else if (ce) begin
      if (wrEn && evtWrAddr == `RTCM_A_FLAGS) begin
        flags_r <= flags_r & wrVal;
      end
      if (oscStopSync) begin
        flags_r[`RTCM_F_OSF] <= 1'b1;
      end
      if (tickDly_r && alarmHit) begin
        flags_r[`RTCM_F_AF] <= 1'b1;
      end
    end
  end

  always_comb begin
    rdVal = `RTCM_BLOCKED_RD;
    if (evtPtr < `RTCM_A_ALM_HUND) begin
      rdVal = snap_r[evtPtr[2:0]];
    end else begin
      case (evtPtr)
        `RTCM_A_ALM_HUND: rdVal = almHund_r;
        `RTCM_A_ALM_SEC: rdVal = almSec_r;
        `RTCM_A_ALM_MIN: rdVal = almMin_r;
        `RTCM_A_ALM_HRS: rdVal = almHrs_r;
        `RTCM_A_ALM_DDT: rdVal = almDdt_r;
        `RTCM_A_CTRL: rdVal = ctrl_r;
        `RTCM_A_FLAGS: rdVal = flags_r;
        default: rdVal = charge_r;
      endcase
    end
    rdVal = rdVal & regMask(evtPtr);
  end

  // next read byte is staged in the cycle the synchronised byte event toggle is seen
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData_r <= `RTCM_RD_RST;
    end else if (ce && evtNew) begin
      rdData_r <= pfSync ? `RTCM_BLOCKED_RD : rdVal;
    end
  end

  assign oscStopOnBattery = ctrl_r[`RTCM_C_OSC_STOP_ON_BATTERY];
  assign batteryOutputEnable = ctrl_r[`RTCM_C_BATTERY_OUTPUT_ENABLE];
  assign waveRateHigh = ctrl_r[`RTCM_C_RS_HI];
  assign waveRateLow = ctrl_r[`RTCM_C_RS_LO];
  assign interruptPinSelect = ctrl_r[`RTCM_C_INTSEL];
  assign alarmIrqEnable = ctrl_r[`RTCM_C_AIE];
  assign alarmMatchFlag = flags_r[`RTCM_F_AF];
  assign oscillatorStopFlag = flags_r[`RTCM_F_OSF];
  assign chargePathSetup = charge_r;
endmodule
`default_nettype wire

// [rtl/rtcm_consts.svh]
// register offsets, field masks, bit positions and reset values of the clock register map
`ifndef RTCM_CONSTS_SVH
`define RTCM_CONSTS_SVH
`define RTCM_A_HUND 4'h0
`define RTCM_A_SEC 4'h1
`define RTCM_A_MIN 4'h2
`define RTCM_A_HRS 4'h3
`define RTCM_A_WDAY 4'h4
`define RTCM_A_DATE 4'h5
`define RTCM_A_MON 4'h6
`define RTCM_A_YEAR 4'h7
`define RTCM_A_ALM_HUND 4'h8
`define RTCM_A_ALM_SEC 4'h9
`define RTCM_A_ALM_MIN 4'ha
`define RTCM_A_ALM_HRS 4'hb
`define RTCM_A_ALM_DDT 4'hc
`define RTCM_A_CTRL 4'hd
`define RTCM_A_FLAGS 4'he
`define RTCM_A_CHARGE 4'hf
`define RTCM_WR_BIT 7
`define RTCM_LAST_BIT 3'h7
`define RTCM_FIRST_BIT 3'h0
`define RTCM_M_FULL 8'hff
`define RTCM_M_SEVEN 8'h7f
`define RTCM_M_WDAY 8'h07
`define RTCM_M_DATE 8'h3f
`define RTCM_M_MON 8'h9f
`define RTCM_M_CTRL 8'hbd
`define RTCM_M_FLAGS 8'h81
`define RTCM_BCD_00 8'h00
`define RTCM_BCD_01 8'h01
`define RTCM_BCD_02 8'h02
`define RTCM_BCD_04 8'h04
`define RTCM_BCD_06 8'h06
`define RTCM_BCD_07 8'h07
`define RTCM_BCD_09 8'h09
`define RTCM_BCD_11 8'h11
`define RTCM_BCD_12 8'h12
`define RTCM_BCD_23 8'h23
`define RTCM_BCD_28 8'h28
`define RTCM_BCD_29 8'h29
`define RTCM_BCD_30 8'h30
`define RTCM_BCD_31 8'h31
`define RTCM_BCD_59 8'h59
`define RTCM_BCD_99 8'h99
`define RTCM_NIB_MASKED 4'hf
`define RTCM_HRS_12H 6
`define RTCM_HRS_PM 5
`define RTCM_MON_CENT 7
`define RTCM_ALM_MASK 7
`define RTCM_ALM_DAY 6
`define RTCM_F_OSF 7
`define RTCM_F_AF 0
`define RTCM_C_OSC_STOP_ON_BATTERY 7
`define RTCM_C_BATTERY_OUTPUT_ENABLE 5
`define RTCM_C_RS_HI 4
`define RTCM_C_RS_LO 3
`define RTCM_C_INTSEL 2
`define RTCM_C_AIE 0
`define RTCM_CTRL_RST 8'h18
`define RTCM_FLAGS_RST 8'h80
`define RTCM_CHARGE_RST 8'h00
`define RTCM_RD_RST 8'h00
`define RTCM_BLOCKED_RD 8'h00
`endif

// [rtl/rtcm_pkg.sv]
// shared types of the clock register block
`default_nettype none
package rtcm_pkg;
  typedef logic [7:0] rtcm_byte_t;
  typedef enum logic [1:0] {PH_ADDR, PH_READ, PH_WRITE} rtcm_phase_t;
endpackage
`default_nettype wire

// [rtl/rtcm_sync.sv]
// two-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ns
`default_nettype none
module rtcm_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      syncOut <= '0;
    end else if (ce) begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [rtl/rtcm_link.sv]
// serial link engine on the link clock: address byte, pointer, byte events and read shifter
`timescale 1ns/1ns
`default_nettype none
`include "rtcm_consts.svh"
module rtcm_link (
  input wire logic linkClk,
  input wire logic linkSel_n,
  input wire logic rst_n,
  input wire logic linkDin,
  input wire logic [7:0] rdByte,
  output logic linkDout,
  output logic linkDoutEn_n,
  output logic evtTog,
  output logic evtWr,
  output logic [3:0] evtWrAddr,
  output logic [7:0] evtData,
  output logic [3:0] evtPtr
);
  rtcm_pkg::rtcm_phase_t phase_r;
  logic [2:0] bitCnt_r;
  logic [6:0] shiftIn_r;
  logic [7:0] shiftOut_r;
  logic [3:0] ptr_r;
  logic [7:0] byteIn;
  logic byteDone;

  assign byteIn = {shiftIn_r, linkDin};
  assign byteDone = bitCnt_r == `RTCM_LAST_BIT;

  // frame state is cleared by the select itself, since the link clock stops between frames
  always_ff @(posedge linkClk or posedge linkSel_n) begin
    if (linkSel_n) begin
      bitCnt_r <= `RTCM_FIRST_BIT;
      shiftIn_r <= '0;
    end else begin
      bitCnt_r <= bitCnt_r + 3'h1;
      shiftIn_r <= byteIn[6:0];
    end
  end

  always_ff @(posedge linkClk or posedge linkSel_n) begin
    if (linkSel_n) begin
      phase_r <= rtcm_pkg::PH_ADDR;
      ptr_r <= '0;
    end else if (byteDone) begin
      case (phase_r)
        rtcm_pkg::PH_ADDR: begin
          ptr_r <= byteIn[3:0];
          phase_r <= byteIn[`RTCM_WR_BIT] ? rtcm_pkg::PH_WRITE : rtcm_pkg::PH_READ;
        end
        rtcm_pkg::PH_READ, rtcm_pkg::PH_WRITE: ptr_r <= ptr_r + 4'h1;
        default: phase_r <= rtcm_pkg::PH_ADDR;
      endcase
    end
  end

  // event words stay put for a whole byte, so the toggle alone needs synchronising
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      evtTog <= 1'b0;
      evtWr <= 1'b0;
      evtWrAddr <= '0;
      evtData <= '0;
      evtPtr <= '0;
    end else if (!linkSel_n && byteDone) begin
      evtTog <= ~evtTog;
      evtWr <= phase_r == rtcm_pkg::PH_WRITE;
      evtWrAddr <= ptr_r;
      evtData <= byteIn;
      evtPtr <= (phase_r == rtcm_pkg::PH_ADDR) ? byteIn[3:0] : ptr_r + 4'h1;
    end
  end

  // read byte is loaded at the first falling edge after the host's inter-byte pause
  always_ff @(negedge linkClk or posedge linkSel_n) begin
    if (linkSel_n) begin
      shiftOut_r <= '0;
    end else if (bitCnt_r == `RTCM_FIRST_BIT && phase_r == rtcm_pkg::PH_READ) begin
      shiftOut_r <= rdByte;
    end else begin
      shiftOut_r <= {shiftOut_r[6:0], 1'b0};
    end
  end

  assign linkDout = shiftOut_r[7];
  assign linkDoutEn_n = phase_r != rtcm_pkg::PH_READ;
endmodule
`default_nettype wire

// [testbench/rtcm_host_model.sv]
// serial host controller model driving the clock device's link pins
`timescale 1ns/1ns
`default_nettype none
module rtcm_host_model (
  output logic linkClk,
  output logic linkSel_n,
  output logic linkDin,
  input wire logic linkDout,
  input wire logic linkDoutEn_n
);
  initial begin
    linkClk = 1'b1;
    linkSel_n = 1'b0;
    linkDin = 1'b0;
    // short select pulse clears the frame flops, whose only reset is the select
    #2 linkSel_n = 1'b1;
  end

  // one byte msb first; clock idles high, sampled on the rise
  task automatic shift(input logic [7:0] txByte, output logic [7:0] rxByte);
    for (int i = 7; i >= 0; i--) begin
      #3 linkClk = 1'b0;
      linkDin = txByte[i];
      #3 linkClk = 1'b1;
      rxByte[i] = linkDout;
    end
    // hold past the edge, then show a changed level so a stale bit is not read twice
    #1 linkDin = ~linkDin;
    #199;
  endtask

  task automatic xfer(input logic wrMode, input logic [3:0] regIdx, input logic [7:0] txq[$],
                      output logic [7:0] rxq[$]);
    logic [7:0] b;
    rxq = {};
    // odd offset keeps link edges off the system clock grid
    #1 linkSel_n = 1'b0;
    #100;
    shift({wrMode, 3'h0, regIdx}, b);
    foreach (txq[k]) begin
      shift(txq[k], b);
      rxq.push_back(b);
    end
    linkSel_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// [testbench/rtcm_top_properties.sv]
// concurrent checks on the ports of the clock register block
`timescale 1ns/1ns
`default_nettype none
module rtcm_top_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hundTick,
  input wire logic powerFail,
  input wire logic oscStopped,
  input wire logic linkSel_n,
  input wire logic linkDout,
  input wire logic linkDoutEn_n,
  input wire logic oscStopOnBattery,
  input wire logic batteryOutputEnable,
  input wire logic waveRateHigh,
  input wire logic waveRateLow,
  input wire logic interruptPinSelect,
  input wire logic alarmIrqEnable,
  input wire logic alarmMatchFlag,
  input wire logic oscillatorStopFlag,
  input wire logic [7:0] chargePathSetup
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    linkSel_n [*8];
  endsequence
  sequence s_pfHeld;
    powerFail [*8];
  endsequence
  property p_resetCtrl;
    $rose(rst_n) |-> waveRateHigh && waveRateLow && oscillatorStopFlag && !alarmMatchFlag && !alarmIrqEnable;
  endproperty
  property p_resetCharge;
    $rose(rst_n) |-> chargePathSetup == 8'h00 && !oscStopOnBattery && !batteryOutputEnable;
  endproperty
  property p_idleBus;
    linkSel_n [*2] |-> linkDoutEn_n && !linkDout;
  endproperty
  property p_enFall;
    $fell(linkDoutEn_n) |-> !linkSel_n && !$past(linkSel_n, 5);
  endproperty
  property p_enHold;
    !linkDoutEn_n && !linkSel_n |=> linkSel_n || !linkDoutEn_n;
  endproperty
  property p_flagCause;
    $rose(alarmMatchFlag) |-> $past(hundTick, 2) || $past(hundTick, 3);
  endproperty
  property p_flagHold;
    (s_quiet ##0 alarmMatchFlag) |=> alarmMatchFlag;
  endproperty
  property p_ctrlQuiet;
    s_quiet |=> $stable({oscStopOnBattery, batteryOutputEnable, waveRateHigh, waveRateLow,
                         interruptPinSelect, alarmIrqEnable, chargePathSetup});
  endproperty
  property p_pfReadZero;
    (s_pfHeld ##0 !linkDoutEn_n) |-> !linkDout;
  endproperty
  property p_oscFlag;
    oscStopped [*4] |=> oscillatorStopFlag;
  endproperty
  a_resetCtrl: assert property (p_resetCtrl)
    else $error("control or status output not at its reset value");
  a_resetCharge: assert property (p_resetCharge)
    else $error("charger or battery bits not at reset value");
  a_idleBus: assert property (p_idleBus)
    else $error("data out driven while deselected");
  a_enFall: assert property (p_enFall)
    else $error("read enable fell too early in a frame");
  a_enHold: assert property (p_enHold)
    else $error("read enable released inside a frame");
  a_flagCause: assert property (p_flagCause)
    else $error("alarm flag rose without a tick");
  a_flagHold: assert property (p_flagHold)
    else $error("alarm flag cleared with no access");
  a_ctrlQuiet: assert property (p_ctrlQuiet)
    else $error("register output changed with no access");
  a_pfReadZero: assert property (p_pfReadZero)
    else $error("read data under power fail not zero");
  a_oscFlag: assert property (p_oscFlag)
    else $error("oscillator stop flag not set");
endmodule
bind rtcm_top rtcm_top_properties i_props (.sys_clk(sys_clk), .rst_n(rst_n), .hundTick(hundTick),
  .powerFail(powerFail), .oscStopped(oscStopped), .linkSel_n(linkSel_n), .linkDout(linkDout),
  .linkDoutEn_n(linkDoutEn_n), .oscStopOnBattery(oscStopOnBattery), .batteryOutputEnable(batteryOutputEnable),
  .waveRateHigh(waveRateHigh), .waveRateLow(waveRateLow), .interruptPinSelect(interruptPinSelect),
  .alarmIrqEnable(alarmIrqEnable), .alarmMatchFlag(alarmMatchFlag), .oscillatorStopFlag(oscillatorStopFlag),
  .chargePathSetup(chargePathSetup));
`default_nettype wire

// [testbench/tb_rtcm_top.sv]
// self-checking bench for the clock register block with a register model
`timescale 1ns/1ns
`default_nettype none
module tb_rtcm_top;
  logic sys_clk, rst_n, hundTick, powerFail, oscStopped;
  wire logic linkClk, linkSel_n, linkDin, linkDout, linkDoutEn_n, alarmMatchFlag, oscillatorStopFlag;
  wire logic oscStopOnBattery, batteryOutputEnable, waveRateHigh, waveRateLow, interruptPinSelect, alarmIrqEnable;
  wire logic [7:0] chargePathSetup;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 22;
  logic [7:0] regModel [16];
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  localparam logic [7:0] KEEP [16] = '{8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h07, 8'h3f, 8'h9f, 8'hff,
                                       8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hbd, 8'h81, 8'hff};

  rtcm_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .hundTick(hundTick), .powerFail(powerFail),
    .oscStopped(oscStopped), .linkClk(linkClk), .linkSel_n(linkSel_n), .linkDin(linkDin), .linkDout(linkDout),
    .linkDoutEn_n(linkDoutEn_n), .oscStopOnBattery(oscStopOnBattery), .batteryOutputEnable(batteryOutputEnable),
    .waveRateHigh(waveRateHigh), .waveRateLow(waveRateLow), .interruptPinSelect(interruptPinSelect),
    .alarmIrqEnable(alarmIrqEnable), .alarmMatchFlag(alarmMatchFlag), .oscillatorStopFlag(oscillatorStopFlag),
    .chargePathSetup(chargePathSetup));
  rtcm_host_model i_host (.linkClk(linkClk), .linkSel_n(linkSel_n), .linkDin(linkDin), .linkDout(linkDout),
    .linkDoutEn_n(linkDoutEn_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #1000000;
    mismatches++;
    test_done();
  end

  task check(input logic [7:0] seen, input logic [7:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, expv);
    end
  endtask

  task test_done;
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task ticks(input int n);
    repeat (n) begin
      @(negedge sys_clk) hundTick = 1'b1;
      @(negedge sys_clk) hundTick = 1'b0;
    end
  endtask

  // status bits clear on 0 and keep on 1, everything else stores through its mask
  task automatic wr(input int a);
    i_host.xfer(1'b1, a[3:0], tx, rx);
    foreach (tx[k])
      regModel[(a + k) % 16] = ((a + k) % 16 == 14) ? regModel[14] & tx[k] : tx[k] & KEEP[(a + k) % 16];
  endtask

  task automatic rd(input int a, input int n);
    tx = {};
    repeat (n) tx.push_back(8'($random(seed)));
    i_host.xfer(1'b0, a[3:0], tx, rx);
    foreach (rx[k]) check(rx[k], regModel[(a + k) % 16]);
  endtask

  task ctl_check;
    check({oscStopOnBattery, 1'b0, batteryOutputEnable, waveRateHigh, waveRateLow, interruptPinSelect, 1'b0,
           alarmIrqEnable}, regModel[13]);
    check({oscillatorStopFlag, 6'h00, alarmMatchFlag}, regModel[14]);
    check(chargePathSetup, regModel[15]);
  endtask

  task set_time(input logic [7:0] v [8]);
    for (int k = 0; k < 8; k++) regModel[k] = v[k];
  endtask

  task do_reset;
    @(negedge sys_clk);
    rst_n = 1'b0;
    cycles(2);
    rst_n = 1'b1;
    cycles(4);
    regModel[13] = 8'h18;
    regModel[14] = 8'h80;
    regModel[15] = 8'h00;
  endtask

  initial begin
    hundTick = 1'b0;
    powerFail = 1'b0;
    oscStopped = 1'b0;
    do_reset();
    ctl_check();
    rd(13, 3);
    for (int i = 0; i < 4; i++) begin
      tx = {};
      repeat (18) tx.push_back(8'($random(seed)));
      wr($random(seed) & 15);
      rd(i * 5, 17);
      ctl_check();
    end
    // every alarm field masked, then a year-end rollover during a read
    tx = '{8'hff, 8'h80, 8'h80, 8'h80, 8'h80};
    wr(8);
    tx = '{8'h98, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
    wr(0);
    tx = '{8'h00};
    wr(14);
    fork
      rd(0, 8);
      begin
        #300;
        ticks(3);
      end
    join
    set_time('{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00});
    regModel[14] = 8'h01;
    rd(0, 16);
    ctl_check();
    // hundredths and seconds fields unmasked; 11 pm rolls to 12 am and the next day
    tx = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
    wr(8);
    tx = '{8'h00};
    wr(14);
    tx = '{8'h98, 8'h59, 8'h59, 8'h71};
    wr(0);
    check({7'h00, alarmMatchFlag}, 8'h00);
    ticks(1);
    cycles(2);
    check({7'h00, alarmMatchFlag}, 8'h00);
    ticks(1);
    cycles(4);
    set_time('{8'h00, 8'h00, 8'h00, 8'h52, 8'h02, 8'h02, 8'h81, 8'h00});
    regModel[14] = 8'h01;
    rd(0, 16);
    ctl_check();
    // power fail drops the write and blanks the reads
    @(negedge sys_clk) powerFail = 1'b1;
    cycles(4);
    tx = '{~regModel[15]};
    i_host.xfer(1'b1, 4'hf, tx, rx);
    tx = '{8'h00, 8'h00};
    i_host.xfer(1'b0, 4'hd, tx, rx);
    foreach (rx[k]) check(rx[k], 8'h00);
    @(negedge sys_clk) powerFail = 1'b0;
    cycles(4);
    rd(13, 3);
    @(negedge sys_clk) oscStopped = 1'b1;
    cycles(6);
    oscStopped = 1'b0;
    cycles(4);
    regModel[14][7] = 1'b1;
    ctl_check();
    tx = '{8'h01};
    wr(14);
    rd(14, 1);
    // time and alarm contents survive a second reset
    do_reset();
    rd(0, 16);
    ctl_check();
    test_done();
  end
endmodule
`default_nettype wire
